// [verilog/ibr_pkg.sv]
/*
 * Package for the serial bus status, baud and data buffer registers.
 * Assumes a 32-bit Avalon-MM slave port with word addressing.
 */
package ibr_pkg;
    // ------------------------------------------------------------
    // Register word offsets
    // ------------------------------------------------------------
    localparam logic [2:0] OFF_STATUS = 3'h0;
    localparam logic [2:0] OFF_BAUD0 = 3'h1;
    localparam logic [2:0] OFF_DATA = 3'h2;
    localparam logic [2:0] OFF_OWNADDR = 3'h3;
    localparam logic [2:0] OFF_EVT_STS = 3'h4;
    localparam logic [2:0] OFF_EVT_CLR = 3'h5;
    localparam logic [2:0] OFF_EVT_EN = 3'h6;
    // ------------------------------------------------------------
    // Status / control-two bit positions
    // ------------------------------------------------------------
    localparam int B_LASTBIT = 0;
    localparam int B_GCALL = 1;
    localparam int B_AHIT = 2;
    localparam int B_ALOST = 3;
    localparam int B_IRQN = 4;
    localparam int B_BUSY = 5;
    localparam int B_XMIT = 6;
    localparam int B_MASTER = 7;
    // ------------------------------------------------------------
    // Baud register zero layout and reset values
    // ------------------------------------------------------------
    localparam int B_IDLE_RUN = 6;
    localparam logic [7:0] BAUD0_FIXED = 8'hBE;
    localparam logic [7:0] BAUD0_FIXED_MASK = 8'hBF;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] OWNADDR_RST = 8'h00;
    // ------------------------------------------------------------
    // Event bits: byte done, arbitration lost, stop, address hit
    // ------------------------------------------------------------
    localparam int EVT_N = 4;
    localparam int E_BYTE = 0;
    localparam int E_ALOST = 1;
    localparam int E_STOP = 2;
    localparam int E_AHIT = 3;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;

    typedef enum logic [2:0] {
        PH_FREE = 3'b001,
        PH_ADDR = 3'b010,
        PH_DATA = 3'b100
    } ibr_phase_e;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [31:0] wdata;
        logic be0;
    } ibr_req_s;
endpackage

// [verilog/ibr_i2c_regs.sv]
/*
 * Bus-mode status, baud register zero, data buffer and event logic
 * of a serial bus interface, with a light bit-level link follower.
 * Assumes Avalon-MM with waitrequest on mclk and raw bus pins from
 * outside the clock domain; the open-drain wire is resolved outside.
 */
// Notes on behaviour
// R1: Status address reads status; writes there land in control register two.
// R2: Status bits: last bit, general call, hit, lost, irq, busy, transmit, master.
// R3: General call detection also sets the own-address hit flag.
// R4: Unused upper bits of all three registers read zero and reset zero.
// R5: Baud bit 6 chooses stop or keep running while in IDLE.
// R6: Software always writes zero into baud bit 0.
// R7: Fixed baud bits other than bit 0, including bit 7, always read back as one; bit 0 reads zero.
// R8: Eight-bit data buffer, reset zero: read gives received, write transmits.
// R9: Transmit data left-aligned, MSB first; received data right-aligned.
// R10: Separate read and write storage; written data is never read back.
// R11: Hardware clears master select on stop condition or arbitration loss.
// R12: In slave mode transmit select follows the received direction bit.
module ibr_i2c_regs #(
    parameter int ADDR_W = 3
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic idleMode,
    output logic idleStopped,
    output logic masterSelect,
    output logic serialBusIrq
);
    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (ADDR_W < 3) begin : g_chk
        $error("ADDR_W must be at least 3");
    end

    // ------------------------------------------------------------
    // Bus request carrier and decode
    // ------------------------------------------------------------
    ibr_pkg::ibr_req_s req;
    logic waitFf;
    logic [31:0] rdataFf;
    logic hiAddr;
    logic busTake;
    logic busWr;
    logic busRdLatch;
    logic [31:0] rdMux;

    assign hiAddr = (ADDR_W > 3) ? |(address >> 3) : 1'b0;
    assign req.rd = read;
    assign req.wr = write;
    assign req.addr = hiAddr ? 3'h7 : address[2:0];
    assign req.wdata = writedata;
    assign req.be0 = byteenable[0];
    assign busTake = (req.rd | req.wr) & ~waitFf;
    assign busWr = busTake & req.wr & req.be0;
    assign busRdLatch = req.rd & waitFf;

    wire wrStatus = busWr & (req.addr == ibr_pkg::OFF_STATUS);
    wire wrBaud = busWr & (req.addr == ibr_pkg::OFF_BAUD0);
    wire wrData = busWr & (req.addr == ibr_pkg::OFF_DATA);
    wire wrOwn = busWr & (req.addr == ibr_pkg::OFF_OWNADDR);
    wire wrClr = busWr & (req.addr == ibr_pkg::OFF_EVT_CLR);
    wire wrEn = busWr & (req.addr == ibr_pkg::OFF_EVT_EN);
    wire rdData = busTake & req.rd & (req.addr == ibr_pkg::OFF_DATA);

    // ------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------
    logic [1:0] sclSyncFf;
    logic [1:0] sdaSyncFf;
    logic sclPrevFf;
    logic sdaPrevFf;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sclSyncFf <= 2'h3;
            sdaSyncFf <= 2'h3;
            sclPrevFf <= 1'b1;
            sdaPrevFf <= 1'b1;
        end else begin
            sclSyncFf <= {sclSyncFf[0], sclIn};
            sdaSyncFf <= {sdaSyncFf[0], sdaIn};
            sclPrevFf <= sclSyncFf[1];
            sdaPrevFf <= sdaSyncFf[1];
        end
    end

    wire scl = sclSyncFf[1];
    wire sda = sdaSyncFf[1];
    logic idleRunFf;
    // Whole link follower freezes while stopped in IDLE
    wire run = ~(idleMode & ~idleRunFf); // R5
    wire sclRise = run & scl & ~sclPrevFf;
    wire sclFall = run & ~scl & sclPrevFf;
    wire startSeen = run & scl & sclPrevFf & ~sda & sdaPrevFf;
    wire stopSeen = run & scl & sclPrevFf & sda & ~sdaPrevFf;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    ibr_pkg::ibr_phase_e phaseFf;
    ibr_pkg::ibr_phase_e nxt_phase;
    logic [3:0] bitCntFf;
    logic [6:0] shiftFf;
    logic [7:0] rxBufFf;
    logic [7:0] txBufFf;
    logic [7:0] ownAddrFf;
    logic lastBitFf;
    logic gcallFf;
    logic ahitFf;
    logic alostFf;
    logic irqnFf;
    logic busyFf;
    logic xmitSelFf;
    logic masterFf;
    logic sdaOeFf;
    logic [ibr_pkg::EVT_N-1:0] evtStsFf;
    logic [ibr_pkg::EVT_N-1:0] evtEnFf;
    logic irqFf;
    logic [7:0] statusVec;
    logic [7:0] baudVec;

    // Received byte is right-aligned, last bit on the LSB
    wire byteDone = sclRise & (bitCntFf == ibr_pkg::BIT_LAST);
    wire [7:0] rxByte = {shiftFf, sda}; // R9
    wire gcallHit = byteDone & (phaseFf == ibr_pkg::PH_ADDR)
        & (rxByte == 8'h00);
    wire ownHit = byteDone & (phaseFf == ibr_pkg::PH_ADDR)
        & (rxByte[7:1] == ownAddrFf[7:1]);
    wire addrHit = gcallHit | ownHit;
    // Released line read back low while we send a one
    wire arbLostEvt = sclRise & masterFf & xmitSelFf & ~sdaOeFf & ~sda
        & (bitCntFf < ibr_pkg::BIT_ACK);
    wire [3:0] txIdx = ibr_pkg::BIT_LAST - bitCntFf;
    wire txBit = txBufFf[txIdx[2:0]];
    // Slave never drives while an address byte comes in
    wire txDrive = xmitSelFf & (masterFf | (phaseFf == ibr_pkg::PH_DATA));

    // ------------------------------------------------------------
    // Link phase machine
    // ------------------------------------------------------------
    always_comb begin
        nxt_phase = phaseFf;
        case (phaseFf)
            ibr_pkg::PH_FREE: begin
                if (startSeen) begin
                    nxt_phase = ibr_pkg::PH_ADDR;
                end
            end
            ibr_pkg::PH_ADDR: begin
                if (stopSeen) begin
                    nxt_phase = ibr_pkg::PH_FREE;
                end else if (byteDone) begin
                    nxt_phase = ibr_pkg::PH_DATA;
                end
            end
            ibr_pkg::PH_DATA: begin
                if (stopSeen) begin
                    nxt_phase = ibr_pkg::PH_FREE;
                end else if (startSeen) begin
                    nxt_phase = ibr_pkg::PH_ADDR;
                end
            end
            default: nxt_phase = ibr_pkg::PH_FREE;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            phaseFf <= ibr_pkg::PH_FREE;
            bitCntFf <= 4'h0;
            shiftFf <= 7'h00;
        end else begin
            phaseFf <= nxt_phase;
            if (startSeen || stopSeen) begin
                bitCntFf <= 4'h0;
            end else if (sclRise) begin
                bitCntFf <= (bitCntFf == ibr_pkg::BIT_ACK) ? 4'h0
                    : bitCntFf + 4'h1;
                shiftFf <= {shiftFf[5:0], sda};
            end
        end
    end

    // ------------------------------------------------------------
    // Status flags and control register two
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            lastBitFf <= 1'b0;
            gcallFf <= 1'b0;
            ahitFf <= 1'b0;
            alostFf <= 1'b0;
            irqnFf <= 1'b1;
            busyFf <= 1'b0;
            xmitSelFf <= 1'b0;
            masterFf <= 1'b0;
        end else begin
            if (wrStatus) begin
                xmitSelFf <= req.wdata[ibr_pkg::B_XMIT]; // R1
                masterFf <= req.wdata[ibr_pkg::B_MASTER]; // R1
                alostFf <= 1'b0;
            end
            if (startSeen) begin
                busyFf <= 1'b1;
                gcallFf <= 1'b0;
                ahitFf <= 1'b0;
            end
            if (stopSeen) begin
                busyFf <= 1'b0;
                masterFf <= 1'b0; // R11
            end
            if (arbLostEvt) begin
                alostFf <= 1'b1;
                masterFf <= 1'b0; // R11
            end
            if (byteDone) begin
                lastBitFf <= sda;
            end
            if (gcallHit) begin
                gcallFf <= 1'b1;
            end
            if (addrHit) begin
                ahitFf <= 1'b1; // R3
            end
            if (addrHit && !masterFf) begin
                xmitSelFf <= rxByte[0]; // R12
            end
            // Request pending until software touches the buffer or writes status with bit 4 set
            if (byteDone || arbLostEvt) begin
                irqnFf <= 1'b0;
            end else if (rdData || wrData
                || (wrStatus && req.wdata[ibr_pkg::B_IRQN])) begin
                irqnFf <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Baud zero, own address, data buffers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            idleRunFf <= 1'b0;
            ownAddrFf <= ibr_pkg::OWNADDR_RST;
            rxBufFf <= ibr_pkg::DATA_RST;
            txBufFf <= ibr_pkg::DATA_RST;
        end else begin
            if (wrBaud) begin
                idleRunFf <= req.wdata[ibr_pkg::B_IDLE_RUN]; // R5
            end
            if (wrOwn) begin
                ownAddrFf <= req.wdata[7:0];
            end
            if (byteDone) begin
                rxBufFf <= rxByte; // R8
            end
            // Write side kept apart so reads never see it
            if (wrData) begin
                txBufFf <= req.wdata[7:0]; // R10
            end
        end
    end

    // ------------------------------------------------------------
    // Data drive: MSB first, changed on the falling clock
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sdaOeFf <= 1'b0;
        end else if (startSeen || stopSeen || arbLostEvt) begin
            sdaOeFf <= 1'b0;
        end else if (sclFall) begin
            sdaOeFf <= txDrive & (bitCntFf < ibr_pkg::BIT_ACK)
                & ~txBit; // R9
        end
    end

    // ------------------------------------------------------------
    // Events, mask and interrupt line
    // ------------------------------------------------------------
    logic [ibr_pkg::EVT_N-1:0] evtSet;
    assign evtSet[ibr_pkg::E_BYTE] = byteDone;
    assign evtSet[ibr_pkg::E_ALOST] = arbLostEvt;
    assign evtSet[ibr_pkg::E_STOP] = stopSeen;
    assign evtSet[ibr_pkg::E_AHIT] = addrHit;

    for (genvar i = 0; i < ibr_pkg::EVT_N; i++) begin : g_evt
        // Set beats a clear landing on the same edge
        always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
                evtStsFf[i] <= 1'b0;
            end else if (evtSet[i]) begin
                evtStsFf[i] <= 1'b1;
            end else if (wrClr && req.wdata[i]) begin
                evtStsFf[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            evtEnFf <= '0;
            irqFf <= 1'b0;
        end else begin
            if (wrEn) begin
                evtEnFf <= req.wdata[ibr_pkg::EVT_N-1:0];
            end
            irqFf <= |(evtStsFf & evtEnFf);
        end
    end

    // ------------------------------------------------------------
    // Read mux and bus handshake
    // ------------------------------------------------------------
    assign statusVec = {masterFf, xmitSelFf, busyFf, irqnFf, alostFf,
        ahitFf, gcallFf, lastBitFf}; // R2
    assign baudVec = ibr_pkg::BAUD0_FIXED
        | ({7'h00, idleRunFf} << ibr_pkg::B_IDLE_RUN); // R7

    // Upper bits zero-padded on every mapped word
    assign rdMux =
        (req.addr == ibr_pkg::OFF_STATUS) ? {24'h0, statusVec} : // R4
        (req.addr == ibr_pkg::OFF_BAUD0) ? {24'h0, baudVec} :
        (req.addr == ibr_pkg::OFF_DATA) ? {24'h0, rxBufFf} :
        (req.addr == ibr_pkg::OFF_OWNADDR) ? {24'h0, ownAddrFf} :
        (req.addr == ibr_pkg::OFF_EVT_STS) ? {28'h0, evtStsFf} :
        (req.addr == ibr_pkg::OFF_EVT_EN) ? {28'h0, evtEnFf} :
        32'h0;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            waitFf <= 1'b1;
            rdataFf <= 32'h0;
            idleStopped <= 1'b0;
        end else begin
            // One wait cycle: latch data, then drop waitrequest
            waitFf <= ~((req.rd | req.wr) & waitFf);
            if (busRdLatch) begin
                rdataFf <= rdMux;
            end
            idleStopped <= ~run;
        end
    end

    assign readdata = rdataFf;
    assign waitrequest = waitFf;
    assign sdaOut = 1'b0;
    assign sdaOe = sdaOeFf;
    assign masterSelect = masterFf;
    assign serialBusIrq = irqFf;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    sequence s_rd_taken(logic [2:0] off);
        read && waitrequest && req.addr == off ##1 !waitrequest;
    endsequence

    property p_status_rd;
        s_rd_taken(ibr_pkg::OFF_STATUS)
            |-> readdata[7:0] == $past(statusVec);
    endproperty
    a_status_rd: assert property (p_status_rd) // R1
        else $error("status read mismatch");

    property p_upper_zero;
        !waitrequest && read |-> readdata[31:8] == 24'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) // R4
        else $error("upper read bits not zero");

    property p_baud_fixed;
        s_rd_taken(ibr_pkg::OFF_BAUD0)
            |-> (readdata[7:0] & ibr_pkg::BAUD0_FIXED_MASK)
                == ibr_pkg::BAUD0_FIXED;
    endproperty
    a_baud_fixed: assert property (p_baud_fixed) // R7
        else $error("baud fixed bits wrong");

    property p_idle_run;
        wrBaud |=> idleRunFf == $past(writedata[6]);
    endproperty
    a_idle_run: assert property (p_idle_run) // R5
        else $error("idle run bit not stored");

    property p_gcall_hit;
        $rose(gcallFf) |-> ahitFf;
    endproperty
    a_gcall_hit: assert property (p_gcall_hit) // R3
        else $error("general call without hit");

    property p_data_rd;
        s_rd_taken(ibr_pkg::OFF_DATA)
            |-> readdata[7:0] == $past(rxBufFf);
    endproperty
    a_data_rd: assert property (p_data_rd) // R10
        else $error("data read not receive side");

    property p_rx_store;
        byteDone |=> rxBufFf == $past(rxByte);
    endproperty
    a_rx_store: assert property (p_rx_store) // R8
        else $error("received byte not stored");

    property p_mst_clear;
        (stopSeen || arbLostEvt) |=> !masterFf;
    endproperty
    a_mst_clear: assert property (p_mst_clear) // R11
        else $error("master select not cleared");

    property p_dir_bit;
        addrHit && !masterFf |=> xmitSelFf == $past(rxByte[0]);
    endproperty
    a_dir_bit: assert property (p_dir_bit) // R12
        else $error("direction bit not loaded");

    property p_msb_first;
        sclFall && txDrive && bitCntFf == 4'h0 && !startSeen
            && !stopSeen |=> sdaOeFf == !$past(txBufFf[7]);
    endproperty
    a_msb_first: assert property (p_msb_first) // R9
        else $error("first bit not MSB");
endmodule

// [verif/ibr_i2c_peer.sv]
/*
 * Far-side bus party: another master or slave on the two-wire bus.
 * Assumes a driven clock and an open-drain data wire resolved by the bench; the
 * clock stands high between frames and only moves inside tasks.
 */
module ibr_i2c_peer (
    output logic sclLine,
    output logic sdaPull,
    input wire logic sdaBus
);
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------
    // Frame pieces, 200 ns bit period
    // ------------------------------------------------------------
    initial begin
        sclLine = 1'b1;
        sdaPull = 1'b0;
    end
    // Small offset keeps pin moves clear of the mclk sampling edge
    task automatic startCond();
        #2;
        sdaPull = 1'b0;
        sclLine = 1'b1;
        #100 sdaPull = 1'b1;
        #100 sclLine = 1'b0;
    endtask
    // Long low phase: slave data must settle before the rise
    task automatic clockBit(input logic pull, output logic seen);
        #70 sdaPull = pull;
        #70 sclLine = 1'b1;
        #60 seen = sdaBus;
        sclLine = 1'b0;
    endtask
    task automatic putByte(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clockBit(~b[i], s);
        end
        clockBit(1'b0, s);
    endtask
    // Ends with a released acknowledge slot
    task automatic getByte(output logic [7:0] b);
        logic s;
        #2;
        for (int i = 7; i >= 0; i--) begin
            clockBit(1'b0, s);
            b[i] = s;
        end
        clockBit(1'b0, s);
    endtask
    task automatic stopCond();
        #2;
        #70 sdaPull = 1'b1;
        #70 sclLine = 1'b1;
        #100 sdaPull = 1'b0;
        #100;
    endtask
endmodule

// [verif/ibr_i2c_regs_bench.sv]
/*
 * Self-checking bench for the status, baud and data buffer registers.
 * Assumes the peer model drives the bus pins and the Avalon tasks below
 * are the only register master.
 */
module ibr_i2c_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, rstn, read, write, idleMode;
    logic [2:0] address;
    logic [31:0] writedata, readdata, rdv;
    logic [3:0] byteenable;
    logic waitrequest, sdaOut, sdaOe, idleStopped, masterSelect;
    logic serialBusIrq, sclLine, sdaPull;
    logic [7:0] rxb;
    wire sdaBus;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    // Pull-up on the data wire; either party may pull it low
    assign sdaBus = ~(sdaPull | sdaOe);

    ibr_i2c_regs #(.ADDR_W(3)) dut_u (
        .mclk(mclk), .rstn(rstn), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .sclIn(sclLine),
        .sdaIn(sdaBus), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .idleMode(idleMode), .idleStopped(idleStopped),
        .masterSelect(masterSelect), .serialBusIrq(serialBusIrq)
    );
    ibr_i2c_peer peer_u (
        .sclLine(sclLine), .sdaPull(sdaPull), .sdaBus(sdaBus)
    );
    // ------------------------------------------------------------
    // Clock, timeout and verdict
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic final_report();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Whole run is about six hundred cycles; ceiling leaves wide margin
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end
    // ------------------------------------------------------------
    // Register bus tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Held until waitrequest is sampled low, then released
    task automatic busReq(input logic rd, input logic [2:0] a,
                          input logic [31:0] d, input logic [3:0] be);
        @(posedge mclk);
        read <= rd;
        write <= ~rd;
        address <= a;
        writedata <= d;
        byteenable <= be;
        do @(posedge mclk); while (waitrequest !== 1'b0);
        rdv = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        busReq(1'b0, a, d, 4'h1);
    endtask
    task automatic rdChk(input logic [2:0] a, input logic [31:0] exp,
                         input logic [31:0] m);
        busReq(1'b1, a, 32'h0, 4'h1);
        chk(rdv & m, exp);
    endtask
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 3'h0;
        writedata = 32'h0;
        byteenable = 4'h1;
        idleMode = 1'b0;
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        rdChk(ibr_pkg::OFF_STATUS, 32'h10, 32'hFFFFFFFF);
        rdChk(ibr_pkg::OFF_BAUD0, 32'hBE, 32'hFFFFFFFF);
        rdChk(ibr_pkg::OFF_DATA, 32'h0, 32'hFFFFFFFF);
        rdChk(3'h7, 32'h0, 32'hFFFFFFFF);
        busReq(1'b0, ibr_pkg::OFF_BAUD0, 32'hFFFFFFFE, 4'h0);
        rdChk(ibr_pkg::OFF_BAUD0, 32'hBE, 32'hFFFFFFFF);
        wr(ibr_pkg::OFF_BAUD0, 32'hFFFFFFFE);
        rdChk(ibr_pkg::OFF_BAUD0, 32'hFE, 32'hFFFFFFFF);
        @(posedge mclk);
        idleMode <= 1'b1;
        repeat (3) @(posedge mclk);
        chk(idleStopped, 1'b0);
        wr(ibr_pkg::OFF_BAUD0, 32'h0);
        rdChk(ibr_pkg::OFF_BAUD0, 32'hBE, 32'hFFFFFFFF);
        repeat (3) @(posedge mclk);
        chk(idleStopped, 1'b1);
        peer_u.startCond();
        peer_u.putByte(8'h55);
        peer_u.stopCond();
        rdChk(ibr_pkg::OFF_EVT_STS, 32'h0, 32'hFFFFFFFF);
        @(posedge mclk);
        idleMode <= 1'b0;
        // Slave receive of own address, then slave transmit
        wr(ibr_pkg::OFF_OWNADDR, 32'h54);
        wr(ibr_pkg::OFF_DATA, 32'hA5);
        rdChk(ibr_pkg::OFF_DATA, 32'h0, 32'hFFFFFFFF);
        wr(ibr_pkg::OFF_EVT_EN, 32'h1);
        peer_u.startCond();
        peer_u.putByte(8'h55);
        rdChk(ibr_pkg::OFF_STATUS, 32'h65, 32'hFFFFFFFF);
        chk(serialBusIrq, 1'b1);
        rdChk(ibr_pkg::OFF_DATA, 32'h55, 32'hFFFFFFFF);
        rdChk(ibr_pkg::OFF_EVT_STS, 32'h9, 32'hFFFFFFFF);
        peer_u.getByte(rxb);
        chk(rxb, 8'hA5);
        peer_u.stopCond();
        wr(ibr_pkg::OFF_EVT_CLR, 32'hF);
        rdChk(ibr_pkg::OFF_EVT_STS, 32'h0, 32'hFFFFFFFF);
        repeat (2) @(posedge mclk);
        chk(serialBusIrq, 1'b0);
        rdChk(ibr_pkg::OFF_STATUS, 32'h0, 32'hA0);
        // General call with the byte event masked
        wr(ibr_pkg::OFF_EVT_EN, 32'h0);
        peer_u.startCond();
        peer_u.putByte(8'h00);
        rdChk(ibr_pkg::OFF_STATUS, 32'h26, 32'hFFFFFFFF);
        chk(serialBusIrq, 1'b0);
        peer_u.stopCond();
        // Master select, cleared by a stop
        wr(ibr_pkg::OFF_STATUS, 32'h8B);
        rdChk(ibr_pkg::OFF_STATUS, 32'h80, 32'h88);
        repeat (2) @(posedge mclk);
        chk(masterSelect, 1'b1);
        wr(ibr_pkg::OFF_EVT_CLR, 32'hF);
        peer_u.startCond();
        peer_u.stopCond();
        chk(masterSelect, 1'b0);
        chk(sdaOut, 1'b0);
        rdChk(ibr_pkg::OFF_EVT_STS, 32'h4, 32'h4);
        // Arbitration lost: released high bit overridden by the peer
        wr(ibr_pkg::OFF_STATUS, 32'hC0);
        wr(ibr_pkg::OFF_DATA, 32'hFF);
        wr(ibr_pkg::OFF_EVT_CLR, 32'hF);
        peer_u.startCond();
        peer_u.putByte(8'h00);
        rdChk(ibr_pkg::OFF_STATUS, 32'h08, 32'h88);
        chk(masterSelect, 1'b0);
        rdChk(ibr_pkg::OFF_EVT_STS, 32'h2, 32'h2);
        wr(ibr_pkg::OFF_STATUS, 32'h10);
        rdChk(ibr_pkg::OFF_STATUS, 32'h10, 32'h18);
        peer_u.stopCond();
        final_report();
    end
endmodule
